//--- ccs_regs.svh
// Register offsets, field positions, opcodes and status codes of the command sequencer.
`ifndef CCS_REGS_SVH
`define CCS_REGS_SVH
`define A_CMD 8'h00
`define A_STATUS 8'h04
`define A_PAYLOAD 8'h08
`define A_RESULT 8'h0C
`define A_CTRL 8'h10
`define A_KEY_SEL 8'h14
`define A_KEY_LO 8'h18
`define A_KEY_HI 8'h1C
`define A_UID 8'h20
`define OP_AUTH 4'h1
`define OP_READ 4'h2
`define OP_WRITE 4'h3
`define OP_VWRITE 4'h4
`define OP_ADD 4'h5
`define OP_SUB 4'h6
`define OP_COPY 4'h7
`define OP_AREAD 4'h8
`define OP_AWRITE 4'h9
`define OP_KEYREP 4'hA
`define CMD_START 31
`define CTRL_LVL2 0
`define CTRL_DEAUTH 1
`define CTRL_FLUSH 2
`define P2_LEN4 0
`define P2_ENC 1
`define FL_NEW 0
`define FL_DIV 1
`define FL_REUSE 2
`define ST_OK 8'h00
`define ST_REJECT 8'h01
`define ST_FAIL 8'h02
`define ST_SHORT 8'h03
`define BUF_LAST 6'h3F
`endif

//--- ccs_pkg.sv
// Types shared by the command sequencer and its surroundings.
package ccs_pkg;
    typedef enum logic [3:0] {
        CO_AUTH = 4'h0, CO_READ = 4'h1, CO_WR_ENC = 4'h2, CO_WR_PLAIN = 4'h3, CO_WR4 = 4'h4,
        CO_ADD = 4'h5, CO_SUB = 4'h6, CO_RESTORE = 4'h7, CO_TRANSFER = 4'h8, CO_TRAILER = 4'h9
    } card_op_t;
    typedef struct packed {
        logic [7:0] p2;
        logic [7:0] p1;
        logic [3:0] op;
    } cmd_t;
    typedef struct packed {
        card_op_t op;
        logic [7:0] blk;
        logic [47:0] key;
        logic [3:0] tdea;
        logic div;
        logic [31:0] uid;
        logic [127:0] data;
    } card_req_t;
    typedef struct packed {
        logic done;
        logic ok;
        logic [127:0] rdata;
    } card_resp_t;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01, S_FETCH = 5'h02, S_ISSUE = 5'h04, S_WAIT = 5'h08, S_STORE = 5'h10
    } seq_state_t;
endpackage

//--- classic_card_command_sequencer.sv
// Sector card command sequencer driving card operations toward the reader chip.
//
// Summary of operation
// - Authentication takes its key from the internal store, optionally diversified.
// - Blocks are accessed and read data returned in payload address order.
// - Second parameter bit 0 selects 16 or 4 byte block writes.
// - Single sixteen byte writes are encrypted only after a completed authentication; combined command writes are always sent encrypted.
// - Four byte writes are always sent plain.
// - Value write builds the stored block from value and host address byte.
// - Each add or subtract is followed at once by a transfer to destination.
// - Value copy returns one status code per item in payload order.
// - Combined commands handle several blocks with shared or separate authentications.
// - Key replace builds the trailer stream only while authenticated.
// - Key replace may diversify using stored key, its TDEA key, UID, block.
// - After newer card authentication only authenticate and combined commands are accepted first.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "ccs_regs.svh"
module classic_card_command_sequencer (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output ccs_pkg::card_req_t card_req,
    output logic card_valid,
    input wire logic card_ready,
    input wire ccs_pkg::card_resp_t card_resp
);
    import ccs_pkg::*;

    // ********************
    // State
    // ********************
    logic [7:0] pay_mem [0:63];
    logic [7:0] res_mem [0:63];
    logic [51:0] key_mem [0:15];
    seq_state_t state_reg, state_next;
    cmd_t cmd_reg, cmd_next;
    logic [18:0][7:0] stg_reg, stg_next;
    logic [5:0] plen_reg, plen_next, pptr_reg, pptr_next, rcnt_reg, rcnt_next, rrd_reg, rrd_next;
    logic [4:0] bidx_reg, bidx_next, ilen;
    logic step_reg, step_next, authed_reg, authed_next, lvl2_pend_reg, lvl2_pend_next, err_reg, err_next;
    logic [7:0] code_reg, code_next, res_wd;
    logic [3:0] kref_reg, kref_next, ksel_reg, ksel_next;
    logic [31:0] klo_reg, klo_next, uid_reg, uid_next, rdata_next;
    logic [127:0] rd_reg, rd_next, pk1, pk3;
    card_req_t req_next;
    logic pay_we, res_we, key_we, start, reject, last_step, combo, next_item;
    logic [3:0] wop;
    logic [7:0] wp2;
    logic [31:0] vw;
    logic [7:0] va;

    function automatic logic [4:0] item_len(input logic [3:0] op, input logic len4);
        case (op)
            `OP_AUTH, `OP_AREAD: item_len = 5'd3;
            `OP_READ: item_len = 5'd1;
            `OP_WRITE: item_len = len4 ? 5'd5 : 5'd17;
            `OP_VWRITE, `OP_ADD, `OP_SUB: item_len = 5'd6;
            `OP_COPY: item_len = 5'd2;
            `OP_AWRITE: item_len = 5'd19;
            `OP_KEYREP: item_len = 5'd8;
            default: item_len = 5'd1;
        endcase
    endfunction

    // ********************
    // Command sequencing
    // ********************
    assign wop = reg_wdata[3:0];
    assign wp2 = reg_wdata[23:16];
    assign start = reg_wr && reg_addr == `A_CMD && reg_wdata[`CMD_START] && state_reg == S_IDLE;
    assign reject = wop < `OP_AUTH || wop > `OP_KEYREP || (wp2[`P2_LEN4] && wp2[`P2_ENC]) ||
                    (wop == `OP_KEYREP && !authed_reg) || plen_reg == 6'h00 ||
                    (lvl2_pend_reg && wop != `OP_AUTH && wop != `OP_AREAD && wop != `OP_AWRITE);
    assign ilen = item_len(cmd_reg.op, cmd_reg.p2[`P2_LEN4]);
    assign combo = cmd_reg.op == `OP_AREAD || cmd_reg.op == `OP_AWRITE;
    assign last_step = step_reg || !(combo || cmd_reg.op == `OP_ADD || cmd_reg.op == `OP_SUB ||
                       cmd_reg.op == `OP_COPY);
    assign card_valid = state_reg == S_ISSUE;

    always_comb begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        stg_next = stg_reg;
        plen_next = plen_reg;
        pptr_next = pptr_reg;
        rcnt_next = rcnt_reg;
        rrd_next = rrd_reg;
        bidx_next = bidx_reg;
        step_next = step_reg;
        authed_next = authed_reg;
        lvl2_pend_next = lvl2_pend_reg;
        err_next = err_reg;
        code_next = code_reg;
        kref_next = kref_reg;
        rd_next = rd_reg;
        pay_we = 1'b0;
        res_we = 1'b0;
        res_wd = `ST_OK;
        next_item = 1'b0;
        if (reg_wr && reg_addr == `A_CTRL && reg_wdata[`CTRL_DEAUTH]) begin
            authed_next = 1'b0;
        end
        if (state_reg == S_IDLE && reg_wr && reg_addr == `A_CTRL && reg_wdata[`CTRL_FLUSH]) begin
            plen_next = 6'h00;
            rcnt_next = 6'h00;
            rrd_next = 6'h00;
        end
        if (state_reg == S_IDLE && reg_wr && reg_addr == `A_PAYLOAD && plen_reg != `BUF_LAST) begin
            pay_we = 1'b1;
            plen_next = plen_reg + 6'h01;
        end
        if (reg_rd && reg_addr == `A_RESULT && rrd_reg != rcnt_reg) begin
            rrd_next = rrd_reg + 6'h01;
        end
        case (state_reg)
            S_IDLE: begin
                if (start) begin
                    cmd_next = '{p2: wp2, p1: reg_wdata[15:8], op: wop};
                    err_next = reject;
                    code_next = reject ? `ST_REJECT : `ST_OK;
                    if (!reject) begin
                        state_next = S_FETCH;
                        pptr_next = 6'h00;
                        bidx_next = 5'h00;
                        rcnt_next = 6'h00;
                        rrd_next = 6'h00;
                    end
                end
            end
            S_FETCH: begin
                if (pptr_reg == plen_reg) begin
                    err_next = 1'b1;
                    code_next = `ST_SHORT;
                    state_next = S_IDLE;
                end else begin
                    stg_next[bidx_reg] = pay_mem[pptr_reg];
                    pptr_next = pptr_reg + 6'h01;
                    bidx_next = bidx_reg + 5'h01;
                    if (bidx_reg == ilen - 5'h01) begin
                        state_next = S_ISSUE;
                        bidx_next = 5'h00;
                        step_next = combo && !(stg_reg[0][`FL_NEW] || stg_reg[0][`FL_REUSE]);
                        if (cmd_reg.op == `OP_AUTH || (combo && stg_reg[0][`FL_NEW] && !stg_reg[0][`FL_REUSE])) begin
                            kref_next = stg_reg[1][3:0];
                        end
                    end
                end
            end
            S_ISSUE: begin
                if (card_ready) begin
                    state_next = S_WAIT;
                end
            end
            S_WAIT: begin
                if (card_resp.done) begin
                    if (!card_resp.ok) begin
                        err_next = 1'b1;
                        code_next = `ST_FAIL;
                        state_next = S_IDLE;
                        if (card_req.op == CO_AUTH) begin
                            authed_next = 1'b0;
                        end
                    end else begin
                        if (card_req.op == CO_AUTH) begin
                            authed_next = 1'b1;
                            lvl2_pend_next = 1'b0;
                        end
                        if (!last_step) begin
                            step_next = 1'b1;
                            state_next = S_ISSUE;
                        end else if (card_req.op == CO_READ) begin
                            rd_next = card_resp.rdata;
                            state_next = S_STORE;
                        end else begin
                            res_we = cmd_reg.op == `OP_COPY;
                            next_item = 1'b1;
                        end
                    end
                end
            end
            S_STORE: begin
                res_we = 1'b1;
                res_wd = rd_reg[127:120];
                rd_next = {rd_reg[119:0], 8'h00};
                bidx_next = bidx_reg + 5'h01;
                next_item = bidx_reg == 5'd15;
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (res_we) begin
            rcnt_next = rcnt_reg + 6'h01;
        end
        if (next_item) begin
            bidx_next = 5'h00;
            state_next = pptr_reg == plen_reg ? S_IDLE : S_FETCH;
        end
        if (reg_wr && reg_addr == `A_CTRL && reg_wdata[`CTRL_LVL2]) begin
            lvl2_pend_next = 1'b1;
        end
    end

    // ********************
    // Card request build
    // ********************
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            pk1[8*(15-i) +: 8] = stg_next[i+1];
            pk3[8*(15-i) +: 8] = stg_next[i+3];
        end
        vw = {stg_next[1], stg_next[2], stg_next[3], stg_next[4]};
        va = stg_next[5];
        req_next = '0;
        req_next.uid = uid_reg;
        req_next.key = key_mem[kref_next][47:0];
        req_next.tdea = key_mem[kref_next][51:48];
        req_next.blk = stg_next[0];
        case (cmd_next.op)
            `OP_AUTH: begin
                req_next.op = CO_AUTH;
                req_next.div = stg_next[2][`FL_DIV];
            end
            `OP_READ: begin
                req_next.op = CO_READ;
            end
            `OP_WRITE: begin
                req_next.data = pk1;
                if (cmd_next.p2[`P2_LEN4]) begin
                    req_next.op = CO_WR4;
                    req_next.data[95:0] = 96'h0;
                end else begin
                    req_next.op = authed_next ? CO_WR_ENC : CO_WR_PLAIN;
                end
            end
            `OP_VWRITE: begin
                req_next.op = authed_next ? CO_WR_ENC : CO_WR_PLAIN;
                req_next.data = {vw, ~vw, vw, va, ~va, va, ~va};
            end
            `OP_ADD, `OP_SUB, `OP_COPY: begin
                if (step_next) begin
                    req_next.op = CO_TRANSFER;
                    req_next.blk = stg_next[1];
                end else begin
                    req_next.op = cmd_next.op == `OP_ADD ? CO_ADD : cmd_next.op == `OP_SUB ? CO_SUB : CO_RESTORE;
                    req_next.data[31:0] = {stg_next[2], stg_next[3], stg_next[4], stg_next[5]};
                end
            end
            `OP_AREAD, `OP_AWRITE: begin
                req_next.blk = stg_next[2];
                req_next.div = stg_next[0][`FL_DIV];
                req_next.data = pk3;
                req_next.op = !step_next ? CO_AUTH : cmd_next.op == `OP_AREAD ? CO_READ : CO_WR_ENC;
            end
            `OP_KEYREP: begin
                req_next.op = CO_TRAILER;
                req_next.key = key_mem[stg_next[1][3:0]][47:0];
                req_next.tdea = key_mem[stg_next[1][3:0]][51:48];
                req_next.div = stg_next[7][`FL_DIV];
                req_next.data = {key_mem[stg_next[1][3:0]][47:0], stg_next[3], stg_next[4], stg_next[5],
                                 stg_next[6], key_mem[stg_next[2][3:0]][47:0]};
            end
            default: begin
                req_next.op = CO_READ;
            end
        endcase
    end

    // ********************
    // Register port
    // ********************
    always_comb begin
        ksel_next = ksel_reg;
        klo_next = klo_reg;
        uid_next = uid_reg;
        key_we = 1'b0;
        rdata_next = 32'h0;
        if (reg_wr && reg_addr == `A_KEY_SEL) begin
            ksel_next = reg_wdata[3:0];
        end
        if (reg_wr && reg_addr == `A_KEY_LO) begin
            klo_next = reg_wdata;
        end
        if (reg_wr && reg_addr == `A_KEY_HI) begin
            key_we = 1'b1;
        end
        if (reg_wr && reg_addr == `A_UID) begin
            uid_next = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                `A_CMD: rdata_next = {12'h0, cmd_reg.p2, cmd_reg.p1, cmd_reg.op};
                `A_STATUS: rdata_next = {2'h0, plen_reg, 2'h0, rcnt_reg, code_reg, 4'h0, err_reg, lvl2_pend_reg,
                                         authed_reg, state_reg != S_IDLE};
                `A_RESULT: rdata_next = {24'h0, res_mem[rrd_reg]};
                `A_KEY_SEL: rdata_next = {28'h0, ksel_reg};
                `A_UID: rdata_next = uid_reg;
                default: rdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (pay_we) begin
            pay_mem[plen_reg] <= reg_wdata[7:0];
        end
        if (res_we) begin
            res_mem[rcnt_reg] <= res_wd;
        end
        if (key_we) begin
            key_mem[ksel_reg] <= {reg_wdata[19:0], klo_reg};
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
            cmd_reg <= '0;
            stg_reg <= '0;
            plen_reg <= 6'h00;
            pptr_reg <= 6'h00;
            rcnt_reg <= 6'h00;
            rrd_reg <= 6'h00;
            bidx_reg <= 5'h00;
            step_reg <= 1'b0;
            authed_reg <= 1'b0;
            lvl2_pend_reg <= 1'b0;
            err_reg <= 1'b0;
            code_reg <= `ST_OK;
            kref_reg <= 4'h0;
            rd_reg <= '0;
            card_req <= '0;
            ksel_reg <= 4'h0;
            klo_reg <= 32'h0;
            uid_reg <= 32'h0;
            reg_rdata <= 32'h0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            stg_reg <= stg_next;
            plen_reg <= plen_next;
            pptr_reg <= pptr_next;
            rcnt_reg <= rcnt_next;
            rrd_reg <= rrd_next;
            bidx_reg <= bidx_next;
            step_reg <= step_next;
            authed_reg <= authed_next;
            lvl2_pend_reg <= lvl2_pend_next;
            err_reg <= err_next;
            code_reg <= code_next;
            kref_reg <= kref_next;
            rd_reg <= rd_next;
            card_req <= req_next;
            ksel_reg <= ksel_next;
            klo_reg <= klo_next;
            uid_reg <= uid_next;
            reg_rdata <= rdata_next;
        end
    end

    // ********************
    // Checks
    // ********************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    key_from_store_a: assert property (card_valid && cmd_reg.op == `OP_AUTH |-> card_req.key == key_mem[stg_reg[1][3:0]][47:0]) else $error("auth key not from store");
    payload_order_a: assert property (state_reg != S_IDLE && $past(state_reg) != S_IDLE |-> pptr_reg >= $past(pptr_reg)) else $error("payload order broken");
    len_select_a: assert property (card_valid && cmd_reg.op == `OP_WRITE && cmd_reg.p2[`P2_LEN4] |-> card_req.op == CO_WR4) else $error("length bit ignored");
    enc_auth_a: assert property (card_valid && cmd_reg.op == `OP_WRITE && !cmd_reg.p2[`P2_LEN4] |-> (card_req.op == CO_WR_ENC) == authed_reg) else $error("encryption choice wrong");
    four_plain_a: assert property (card_valid && card_req.op == CO_WR4 |-> card_req.data[95:0] == 96'h0) else $error("four byte write malformed");
    value_form_a: assert property (card_valid && cmd_reg.op == `OP_VWRITE |-> card_req.data[127:96] == ~card_req.data[95:64] && card_req.data[31:24] == ~card_req.data[23:16]) else $error("value block form wrong");
    auto_transfer_a: assert property (state_reg == S_WAIT && card_resp.done && card_resp.ok && card_req.op inside {CO_ADD, CO_SUB} |=> card_valid && card_req.op == CO_TRANSFER && card_req.blk == stg_reg[1]) else $error("transfer missing");
    trailer_auth_a: assert property (card_valid && card_req.op == CO_TRAILER |-> authed_reg) else $error("trailer without authentication");
    lvl2_gate_a: assert property (card_valid && lvl2_pend_reg |-> card_req.op == CO_AUTH) else $error("session not completed first");
    reject_idle_a: assert property (start && reject |=> state_reg == S_IDLE && err_reg && code_reg == `ST_REJECT && !card_valid) else $error("reject not honoured");
    read_done_c: cover property (state_reg == S_STORE && bidx_reg == 5'd15);
    add_xfer_c: cover property (card_valid && card_req.op == CO_TRANSFER && cmd_reg.op == `OP_ADD);
    reject_c: cover property (start && reject);
    combo_write_c: cover property (card_valid && cmd_reg.op == `OP_AWRITE && card_req.op == CO_WR_ENC);
endmodule // classic_card_command_sequencer

//--- card_model.sv
// Behavioural reader chip and card that answers the card operation port.
`timescale 1ns/100ps
module card_model (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic card_valid,
    input wire ccs_pkg::card_req_t card_req,
    output logic card_ready,
    output ccs_pkg::card_resp_t card_resp,
    input wire logic [3:0] lat,
    input wire logic [7:0] bad_blk
);
    import ccs_pkg::*;
    logic [3:0] wait_cnt;
    int n;
    card_op_t ops [64];
    logic [7:0] blks [64];
    card_req_t last;
    // Accepts after lat cycles, answers next cycle and scrambles the lines between answers.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            card_ready <= 1'b0;
            card_resp <= '0;
            wait_cnt <= 4'h0;
            n <= 0;
        end else if (card_valid && card_ready) begin
            ops[n] <= card_req.op;
            blks[n] <= card_req.blk;
            last <= card_req;
            n <= n + 1;
            card_ready <= 1'b0;
            wait_cnt <= 4'h0;
            card_resp <= {1'b1, card_req.blk != bad_blk, {16{card_req.blk}}};
        end else begin
            card_resp.done <= 1'b0;
            card_resp.ok <= ~card_resp.ok;
            card_resp.rdata <= ~card_resp.rdata;
            card_ready <= card_valid && (wait_cnt >= lat);
            wait_cnt <= card_valid ? wait_cnt + 4'h1 : 4'h0;
        end
    end
endmodule // card_model

//--- classic_card_command_sequencer_tb.sv
// Self-checking testbench of the card command sequencer.
`timescale 1ns/100ps
`include "ccs_regs.svh"
module classic_card_command_sequencer_tb;
    import ccs_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] d;
    logic card_ready;
    logic card_valid;
    card_req_t card_req;
    card_resp_t card_resp;
    logic [3:0] lat = 4'h0;
    logic [7:0] bad_blk = 8'hFF;
    int err_total = 0;
    int samples_checked = 0;
    int base;
    logic [7:0] pl [$];
    always #4 core_clk = ~core_clk;
    classic_card_command_sequencer DUT (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .card_req(card_req),
        .card_valid(card_valid), .card_ready(card_ready), .card_resp(card_resp));
    card_model card (.core_clk(core_clk), .resetn(resetn), .card_valid(card_valid), .card_req(card_req),
        .card_ready(card_ready), .card_resp(card_resp), .lat(lat), .bad_blk(bad_blk));
    // ********************
    // Bus and check tasks.
    // ********************
    task automatic chk(logic [127:0] got, logic [127:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask
    task automatic run(logic [3:0] op, logic [7:0] p2);
        wr(`A_CTRL, 32'h4);
        foreach (pl[k]) wr(`A_PAYLOAD, {24'h0, pl[k]});
        base = card.n;
        wr(`A_CMD, {1'b1, 7'h0, p2, 8'h00, 4'h0, op});
        repeat (300) begin
            rd(`A_STATUS);
            if (d[0] === 1'b0) break;
        end
        chk(d[0], 1'b0);
    endtask
    task automatic op_chk(int i, card_op_t o, logic [7:0] b);
        chk(card.ops[base + i], o);
        chk(card.blks[base + i], b);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #(8 * 20000);
        err_total++;
        finish_test();
    end
    // ***********
    // Main tests.
    // ***********
    initial begin
        repeat (16) @(posedge core_clk);
        resetn <= 1'b1;
        rd(`A_STATUS);
        chk(d, 32'h0);
        rd(8'h3C);
        chk(d, 32'h0);
        wr(`A_KEY_SEL, 32'h2);
        wr(`A_UID, 32'h1234ABCD);
        wr(`A_KEY_LO, 32'hA1B2C3D4);
        wr(`A_KEY_HI, 32'h0005E5F6);
        pl = '{8'h04};
        repeat (16) pl.push_back(8'hA5);
        run(`OP_WRITE, 8'h03);
        chk(d[15:8], `ST_REJECT);
        chk(card.n, base);
        run(`OP_WRITE, 8'h00);
        op_chk(0, CO_WR_PLAIN, 8'h04);
        pl = '{8'h01, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        run(`OP_KEYREP, 8'h00);
        chk(d[15:8], `ST_REJECT);
        pl = '{8'h04, 8'h02, 8'h02};
        run(`OP_AUTH, 8'h00);
        op_chk(0, CO_AUTH, 8'h04);
        chk({card.last.key, card.last.div, card.last.tdea}, {48'hE5F6A1B2C3D4, 1'b1, 4'h5});
        chk(d[1], 1'b1);
        pl = '{8'h04};
        repeat (16) pl.push_back(8'h5A);
        run(`OP_WRITE, 8'h00);
        op_chk(0, CO_WR_ENC, 8'h04);
        pl = '{8'h05, 8'h01, 8'h02, 8'h03, 8'h04};
        run(`OP_WRITE, 8'h01);
        op_chk(0, CO_WR4, 8'h05);
        lat = 4'h3;
        pl = '{8'h07, 8'h03};
        run(`OP_READ, 8'h00);
        op_chk(0, CO_READ, 8'h07);
        op_chk(1, CO_READ, 8'h03);
        chk(d[21:16], 6'd32);
        for (int i = 0; i < 32; i++) begin
            rd(`A_RESULT);
            chk(d[7:0], (i < 16) ? 8'h07 : 8'h03);
        end
        lat = 4'h0;
        for (int k = 0; k < 2; k++) begin
            pl = '{8'h05, 8'h06, 8'h01, 8'h00, 8'h00, 8'h00};
            run(`OP_ADD + k[3:0], 8'h00);
            op_chk(0, (k == 0) ? CO_ADD : CO_SUB, 8'h05);
            op_chk(1, CO_TRANSFER, 8'h06);
        end
        pl = '{8'h08, 8'h09, 8'h0A, 8'h0B};
        run(`OP_COPY, 8'h00);
        op_chk(0, CO_RESTORE, 8'h08);
        chk(d[21:16], 6'd2);
        repeat (2) begin
            rd(`A_RESULT);
            chk(d[7:0], `ST_OK);
        end
        pl = '{8'h0C, 8'h11, 8'h22, 8'h33, 8'h44, 8'h0C};
        run(`OP_VWRITE, 8'h00);
        chk(card.last.data, {32'h11223344, ~32'h11223344, 32'h11223344, 32'h0CF30CF3});
        pl = '{8'h01, 8'h02, 8'h14, 8'h04, 8'h00, 8'h15};
        run(`OP_AREAD, 8'h00);
        op_chk(0, CO_AUTH, 8'h14);
        op_chk(1, CO_READ, 8'h14);
        op_chk(2, CO_AUTH, 8'h15);
        op_chk(3, CO_READ, 8'h15);
        wr(`A_CTRL, 32'h1);
        pl = '{8'h04};
        run(`OP_READ, 8'h00);
        chk(d[15:8], `ST_REJECT);
        pl = '{8'h04, 8'h02, 8'h00};
        run(`OP_AUTH, 8'h00);
        chk(d[2], 1'b0);
        pl = '{8'h04};
        run(`OP_READ, 8'h00);
        chk(d[15:8], `ST_OK);
        pl = '{8'h07, 8'h02, 8'h02, 8'hFF, 8'h07, 8'h80, 8'h69, 8'h02};
        run(`OP_KEYREP, 8'h00);
        op_chk(0, CO_TRAILER, 8'h07);
        chk({card.last.key, card.last.tdea}, {48'hE5F6A1B2C3D4, 4'h5});
        chk(card.last.uid, 32'h1234ABCD);
        pl = '{8'h01, 8'h02, 8'h20};
        repeat (16) pl.push_back(8'h3C);
        pl.push_back(8'h00);
        pl.push_back(8'h00);
        pl.push_back(8'h21);
        repeat (16) pl.push_back(8'hC3);
        run(`OP_AWRITE, 8'h00);
        op_chk(0, CO_AUTH, 8'h20);
        op_chk(1, CO_WR_ENC, 8'h20);
        op_chk(2, CO_WR_ENC, 8'h21);
        chk(card.n, base + 3);
        bad_blk = 8'h30;
        pl = '{8'h30};
        run(`OP_READ, 8'h00);
        chk(d[15:8], `ST_FAIL);
        chk(d[21:16], 6'd0);
        wr(`A_CTRL, 32'h2);
        pl = '{8'h04};
        repeat (16) pl.push_back(8'h66);
        run(`OP_WRITE, 8'h00);
        op_chk(0, CO_WR_PLAIN, 8'h04);
        chk(d[1], 1'b0);
        pl = '{8'h04, 8'h02};
        run(`OP_AUTH, 8'h00);
        chk(d[15:8], `ST_SHORT);
        chk(card.n, base);
        finish_test();
    end
endmodule // classic_card_command_sequencer_tb
